// ==== rtl/rss_state_seq.sv ====
`timescale 1ns/100ps
`default_nettype none

module rss_state_seq
   import rss_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              shutdown_pin,
   input  wire logic              spi_sclk,
   input  wire logic              spi_sdi,
   input  wire logic              select_n,
   output logic                   spi_sdo,
   output logic                   spi_sdo_oe_n,
   input  wire logic [2:0]        fast_reg_function_select_a,
   input  wire logic [2:0]        fast_reg_function_select_b,
   input  wire logic [2:0]        fast_reg_function_select_c,
   input  wire logic [2:0]        fast_reg_function_select_d,
   input  wire logic [BYTE_W-1:0] int_status,
   input  wire logic              int_clear,
   input  wire logic              tx_done,
   input  wire logic              rx_done,
   output logic                   interrupt_request_n,
   output logic                   clear_to_send,
   output logic                   initialised,
   output logic [2:0]             op_state,
   output logic                   boot_osc_en,
   output logic                   lp_clk_en,
   output logic                   regulator_en,
   output logic                   xtal_en,
   output logic                   pll_en,
   output logic                   pll_cal_en,
   output logic                   pa_en,
   output logic                   tx_active,
   output logic                   rx_active
);

   // Next-state and fast register source helpers
   function automatic rss_op_t decode_state(logic [BYTE_W-1:0] code,
                                            rss_op_t dflt);
      rss_op_t s;
      s = rss_op_t'(code[ST_FIELD_MSB:0]);
      decode_state = (s == op_shutdown || s == op_por) ? dflt : s;
   endfunction : decode_state

   function automatic logic [TMR_W-1:0] step_len(rss_seq_t s);
      unique case (s)
         seq_idle:   step_len = TMR_ZERO;
         seq_ldo:    step_len = LDO_CYC;
         seq_xtal:   step_len = XTAL_CYC;
         seq_pll:    step_len = PLL_CYC;
         seq_cal:    step_len = CAL_CYC;
         seq_settle: step_len = SETTLE_CYC;
         seq_pa:     step_len = PA_CYC;
         default:    step_len = TMR_ZERO;
      endcase
   endfunction : step_len

   function automatic rss_seq_t step_after(rss_seq_t s, rss_op_t tgt);
      unique case (s)
         seq_ldo:    step_after = seq_xtal;
         seq_xtal:   step_after = (tgt == op_ready) ? seq_idle : seq_pll;
         seq_pll:    step_after = seq_cal;
         seq_cal:    step_after = seq_settle;
         seq_settle: step_after = (tgt == op_tx) ? seq_pa : seq_idle;
         default:    step_after = seq_idle;
      endcase
   endfunction : step_after

   function automatic logic [BYTE_W-1:0] frr_src(logic [2:0] mode,
      rss_op_t vis, logic [BYTE_W-1:0] ints, logic [BYTE_W-1:0] chip,
      rss_seq_t seq);
      unique case (mode)
         FRR_STATE: frr_src = {5'h00, vis};
         FRR_INT:   frr_src = ints;
         FRR_CHIP:  frr_src = chip;
         FRR_SEQ:   frr_src = {5'h00, seq};
         default:   frr_src = IDLE_BYTE;
      endcase
   endfunction : frr_src

   logic              sel_active;
   logic              sel_start;
   logic              sel_end;
   logic              sclk_fall;
   logic              byte_done;
   logic [BYTE_W-1:0] rx_byte;
   logic [BYTE_W-1:0] byte_cnt;

   // Serial pins, synchronised and framed
   rss_spi_port u_port (
      .clk        (clk),
      .rst        (rst),
      .ce         (ce),
      .sclk_pin   (spi_sclk),
      .sdi_pin    (spi_sdi),
      .select_n   (select_n),
      .sel_active (sel_active),
      .sel_start  (sel_start),
      .sel_end    (sel_end),
      .sclk_fall  (sclk_fall),
      .byte_done  (byte_done),
      .rx_byte    (rx_byte),
      .byte_cnt   (byte_cnt)
   );

   logic              sdn_s1_ff;
   logic              sdn_s2_ff;
   rss_op_t           op_ff, nxt_op;
   rss_seq_t          seq_ff, nxt_seq;
   rss_op_t           tgt_ff, nxt_tgt;
   rss_op_t           after_ff, nxt_after;
   rss_op_t           vis_ff;
   logic [TMR_W-1:0]  tmr_ff, nxt_tmr;
   logic [TMR_W-1:0]  age_ff;
   logic              init_ff, nxt_init;
   logic              tx_irq_ff, nxt_tx_irq;
   logic [BYTE_W-1:0] cmd_ff;
   logic [BYTE_W-1:0] param_ff;
   logic [BYTE_W-1:0] snap_ff [N_FAST];
   logic [BYTE_W-1:0] sr_ff;
   logic              load_pend_ff;
   logic [2:0]        fmode [N_FAST];
   logic              oe_n_ff, irq_n_ff, cts_ff, init_out_ff;
   logic [2:0]        state_ff;
   logic [8:0]        en_ff;

   // Command and state decoding
   logic              powered, cts_now, exec, xtal_on, pll_on;
   logic              is_tx_cmd, is_rx_cmd, is_chg_cmd, launch;
   logic              fast_hit, tx_entry, irq_event;
   logic [FIDX_W-1:0] fast_base, fast_idx;
   rss_op_t           chg_tgt, launch_tgt, launch_after;
   rss_seq_t          first_step;
   logic [BYTE_W-1:0] chip_flags, resp;

   assign fmode[0]   = fast_reg_function_select_a;
   assign fmode[1]   = fast_reg_function_select_b;
   assign fmode[2]   = fast_reg_function_select_c;
   assign fmode[3]   = fast_reg_function_select_d;
   assign powered    = (op_ff != op_shutdown) && (op_ff != op_por);
   assign cts_now    = powered && (seq_ff == seq_idle);
   assign xtal_on    = op_ff inside {op_ready, op_tx, op_rx};
   assign pll_on     = op_ff inside {op_tx, op_rx};
   assign exec       = sel_end && cts_now && init_ff;
   assign is_tx_cmd  = cmd_ff == CMD_START_TX;
   assign is_rx_cmd  = cmd_ff == CMD_START_RX;
   assign is_chg_cmd = cmd_ff == CMD_CHANGE_ST;
   assign chg_tgt    = decode_state(param_ff, op_ff);
   assign launch     = is_tx_cmd || is_rx_cmd || (is_chg_cmd &&
                       chg_tgt inside {op_ready, op_tx, op_rx});
   assign launch_tgt = is_tx_cmd ? op_tx : is_rx_cmd ? op_rx : chg_tgt;
   assign launch_after = (is_tx_cmd || is_rx_cmd) ?
                         decode_state(param_ff, op_ready) : op_ready;
   assign first_step = pll_on ? seq_settle :
                       xtal_on ? (launch_tgt == op_ready ? seq_idle : seq_pll)
                               : seq_ldo;
   assign chip_flags = {5'h00, init_ff, cts_now, tx_irq_ff};
   assign tx_entry   = (nxt_op == op_tx) && (op_ff != op_tx);
   assign irq_event  = (op_ff == op_tx) && (age_ff == IRQ_CYC - TMR_ONE);

   // Shutdown pin synchroniser
   always_ff @(posedge clk) begin
      if (rst) begin
         sdn_s1_ff <= 1'b1;
         sdn_s2_ff <= 1'b1;
      end else if (ce) begin
         sdn_s1_ff <= shutdown_pin;
         sdn_s2_ff <= sdn_s1_ff;
      end
   end

   // Operating state and sequencer next values
   always_comb begin
      nxt_op    = op_ff;
      nxt_seq   = seq_ff;
      nxt_tgt   = tgt_ff;
      nxt_after = after_ff;
      nxt_init  = init_ff;
      nxt_tmr   = (tmr_ff != TMR_ZERO) ? tmr_ff - TMR_ONE : tmr_ff;
      if (sdn_s2_ff) begin
         nxt_op   = op_shutdown;
         nxt_seq  = seq_idle;
         nxt_tmr  = TMR_ZERO;
         nxt_init = 1'b0;
      end else if (op_ff == op_shutdown) begin
         nxt_op  = op_por;
         nxt_tmr = POR_CYC;
      end else if (op_ff == op_por) begin
         if (tmr_ff == TMR_ZERO)
            nxt_op = op_standby;
      end else if (seq_ff != seq_idle) begin
         if (tmr_ff == TMR_ZERO) begin
            nxt_seq = step_after(seq_ff, tgt_ff);
            nxt_tmr = step_len(nxt_seq);
            if (nxt_seq == seq_idle)
               nxt_op = tgt_ff;
         end
      end else begin
         if ((op_ff == op_tx && tx_done) || (op_ff == op_rx && rx_done))
            nxt_op = after_ff;
         if (sel_start && op_ff inside {op_standby, op_sleep})
            nxt_op = op_spi_active;
         if (sel_end && cts_now && cmd_ff == CMD_POWER_UP)
            nxt_init = 1'b1;
         if (exec && launch) begin
            nxt_tgt   = launch_tgt;
            nxt_after = launch_after;
            nxt_seq   = first_step;
            nxt_tmr   = step_len(first_step);
            if (first_step == seq_idle)
               nxt_op = launch_tgt;
         end else if (exec && is_chg_cmd) begin
            nxt_op = chg_tgt;
         end
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (rst) begin
         op_ff    <= op_shutdown;
         seq_ff   <= seq_idle;
         tgt_ff   <= op_ready;
         after_ff <= op_ready;
         tmr_ff   <= TMR_ZERO;
         init_ff  <= 1'b0;
      end else if (ce) begin
         op_ff    <= nxt_op;
         seq_ff   <= nxt_seq;
         tgt_ff   <= nxt_tgt;
         after_ff <= nxt_after;
         tmr_ff   <= nxt_tmr;
         init_ff  <= nxt_init;
      end
   end

   assign nxt_tx_irq = !sdn_s2_ff && (irq_event || (tx_irq_ff && !int_clear));
   always_ff @(posedge clk) begin
      if (rst) begin
         age_ff    <= TMR_ZERO;
         vis_ff    <= op_shutdown;
         tx_irq_ff <= 1'b0;
      end else if (ce) begin
         if (tx_entry)
            age_ff <= TMR_ZERO;
         else if (op_ff == op_tx && age_ff != IRQ_CYC)
            age_ff <= age_ff + TMR_ONE;
         if (op_ff != op_tx || age_ff >= FRR_CYC)
            vis_ff <= op_ff;
         tx_irq_ff <= nxt_tx_irq;   // Set wins over clear
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !powered || sel_start) begin
         cmd_ff   <= CMD_NONE;
         param_ff <= IDLE_BYTE;
      end else if (ce && byte_done) begin
         if (byte_cnt == BYTE_CMD)
            cmd_ff <= rx_byte;
         else if (byte_cnt == BYTE_PAR)
            param_ff <= rx_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !powered) begin
         for (int i = 0; i < N_FAST; i++)
            snap_ff[i] <= IDLE_BYTE;
      end else if (ce && sel_start) begin
         for (int i = 0; i < N_FAST; i++)
            snap_ff[i] <= frr_src(fmode[i], vis_ff, int_status,
                                  chip_flags, seq_ff);
      end
   end

   assign fast_hit  = cmd_ff inside {CMD_FAST_A, CMD_FAST_B,
                                     CMD_FAST_C, CMD_FAST_D};
   assign fast_base = (cmd_ff == CMD_FAST_B) ? 2'h1 :
                      (cmd_ff == CMD_FAST_C) ? 2'h2 :
                      (cmd_ff == CMD_FAST_D) ? 2'h3 : 2'h0;
   assign fast_idx  = fast_base + FIDX_W'(byte_cnt - BYTE_PAR);
   // fast data needs no ready wait
   assign resp = fast_hit ? snap_ff[fast_idx] :
                 (cmd_ff == CMD_READ_CTS && byte_cnt == BYTE_PAR) ?
                 (cts_now ? CTS_READY : CTS_BUSY) : IDLE_BYTE;

   always_ff @(posedge clk) begin
      if (rst || !powered || sel_start) begin
         sr_ff        <= IDLE_BYTE;
         load_pend_ff <= 1'b0;
      end else if (ce) begin
         if (byte_done)
            load_pend_ff <= 1'b1;
         if (sclk_fall) begin
            load_pend_ff <= 1'b0;
            sr_ff <= load_pend_ff ? resp : {sr_ff[BYTE_W-2:0], 1'b0};
         end
      end
   end

   // Registered pin and status outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         oe_n_ff     <= 1'b1;
         irq_n_ff    <= 1'b1;
         cts_ff      <= 1'b0;
         init_out_ff <= 1'b0;
         state_ff    <= 3'h0;
      end else if (ce) begin
         oe_n_ff     <= !(sel_active && nxt_op != op_shutdown &&
                          nxt_op != op_por);
         irq_n_ff    <= !(nxt_tx_irq || (|int_status));
         cts_ff      <= !sdn_s2_ff && nxt_seq == seq_idle &&
                        nxt_op != op_shutdown && nxt_op != op_por;
         init_out_ff <= nxt_init;
         state_ff    <= nxt_op;
      end
   end

   // Analog block enables from the next state, so they track state exactly
   always_ff @(posedge clk) begin
      if (rst) begin
         en_ff <= 9'h000;
      end else if (ce) begin
         en_ff[0] <= !(nxt_op inside {op_shutdown, op_standby, op_sleep});
         en_ff[1] <= nxt_op == op_sleep;
         en_ff[2] <= nxt_seq != seq_idle ||
                     nxt_op inside {op_ready, op_tx, op_rx};
         en_ff[3] <= (nxt_seq != seq_idle && nxt_seq != seq_ldo) ||
                     nxt_op inside {op_ready, op_tx, op_rx};
         en_ff[4] <= nxt_seq inside {seq_pll, seq_cal, seq_settle, seq_pa} ||
                     nxt_op inside {op_tx, op_rx};
         en_ff[5] <= nxt_seq == seq_cal;
         en_ff[6] <= nxt_seq == seq_pa ||
                     (nxt_seq == seq_idle && nxt_op == op_tx);
         en_ff[7] <= nxt_seq == seq_idle && nxt_op == op_tx;
         en_ff[8] <= nxt_seq == seq_idle && nxt_op == op_rx;
      end
   end

   assign spi_sdo             = sr_ff[BYTE_W-1];
   assign spi_sdo_oe_n        = oe_n_ff;
   assign interrupt_request_n = irq_n_ff;
   assign clear_to_send       = cts_ff;
   assign initialised         = init_out_ff;
   assign op_state            = state_ff;
   assign boot_osc_en         = en_ff[0];
   assign lp_clk_en           = en_ff[1];
   assign regulator_en        = en_ff[2];
   assign xtal_en             = en_ff[3];
   assign pll_en              = en_ff[4];
   assign pll_cal_en          = en_ff[5];
   assign pa_en               = en_ff[6];
   assign tx_active           = en_ff[7];
   assign rx_active           = en_ff[8];

endmodule : rss_state_seq

`default_nettype wire

// ==== rtl/rss_pkg.sv ====
package rss_pkg;

   // Serial command codes
   localparam logic [7:0] CMD_NONE      = 8'h00;
   localparam logic [7:0] CMD_POWER_UP  = 8'h01;
   localparam logic [7:0] CMD_START_TX  = 8'h02;
   localparam logic [7:0] CMD_START_RX  = 8'h03;
   localparam logic [7:0] CMD_CHANGE_ST = 8'h04;
   localparam logic [7:0] CMD_READ_CTS  = 8'h05;
   localparam logic [7:0] CMD_FAST_A    = 8'h50;
   localparam logic [7:0] CMD_FAST_B    = 8'h51;
   localparam logic [7:0] CMD_FAST_C    = 8'h53;
   localparam logic [7:0] CMD_FAST_D    = 8'h57;

   // Response bytes
   localparam logic [7:0] CTS_READY = 8'hFF;
   localparam logic [7:0] CTS_BUSY  = 8'h00;
   localparam logic [7:0] IDLE_BYTE = 8'h00;

   // Operating states; the low three bits of a state parameter use this code
   typedef enum logic [2:0] {
      op_shutdown, op_por, op_standby, op_sleep,
      op_spi_active, op_ready, op_tx, op_rx
   } rss_op_t;
   localparam int ST_FIELD_MSB = 2;

   // Sequencer steps toward READY, TX or RX
   typedef enum logic [2:0] {
      seq_idle, seq_ldo, seq_xtal, seq_pll, seq_cal, seq_settle, seq_pa
   } rss_seq_t;

   // Fast register source selection
   localparam logic [2:0] FRR_OFF   = 3'h0;
   localparam logic [2:0] FRR_STATE = 3'h1;
   localparam logic [2:0] FRR_INT   = 3'h2;
   localparam logic [2:0] FRR_CHIP  = 3'h3;
   localparam logic [2:0] FRR_SEQ   = 3'h4;
   localparam int         N_FAST    = 4;
   localparam int         FIDX_W    = 2;

   // Serial framing
   localparam int         BYTE_W    = 8;
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [7:0] BYTE_CMD  = 8'h00;
   localparam logic [7:0] BYTE_PAR  = 8'h01;
   localparam int         PIN_SCLK  = 0;
   localparam int         PIN_SDI   = 1;
   localparam int         PIN_SEL   = 2;

   // Timing, times in microseconds at a 40 ns clock
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_POR_CAL_US  = 80;
   localparam int T_LDO_US      = 4;
   localparam int T_XTAL_US     = 100;
   localparam int T_PLL_US      = 4;
   localparam int T_CAL_US      = 40;
   localparam int T_SETTLE_US   = 50;
   localparam int T_PA_US       = 20;
   localparam int T_FRR_US      = 5;
   localparam int T_IRQ_US      = 13;
   localparam int TMR_W         = 12;
   localparam logic [TMR_W-1:0] TMR_ZERO = 12'h000;
   localparam logic [TMR_W-1:0] TMR_ONE  = 12'h001;
   localparam logic [TMR_W-1:0] POR_CYC =
      TMR_W'((T_POR_CAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] LDO_CYC =
      TMR_W'((T_LDO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] XTAL_CYC =
      TMR_W'((T_XTAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] PLL_CYC =
      TMR_W'((T_PLL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] CAL_CYC =
      TMR_W'((T_CAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] SETTLE_CYC =
      TMR_W'((T_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] PA_CYC =
      TMR_W'((T_PA_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] FRR_CYC =
      TMR_W'((T_FRR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] IRQ_CYC =
      TMR_W'((T_IRQ_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage : rss_pkg

// ==== rtl/rss_spi_port.sv ====
`timescale 1ns/100ps
`default_nettype none

module rss_spi_port
   import rss_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             sclk_pin,
   input  wire logic             sdi_pin,
   input  wire logic             select_n,
   output logic                  sel_active,
   output logic                  sel_start,
   output logic                  sel_end,
   output logic                  sclk_fall,
   output logic                  byte_done,
   output logic [BYTE_W-1:0]     rx_byte,
   output logic [BYTE_W-1:0]     byte_cnt
);

   logic [2:0]        s1_ff;
   logic [2:0]        s2_ff;
   logic [2:0]        s3_ff;
   logic [2:0]        bit_ff;
   logic [BYTE_W-1:0] sr_ff;
   logic [BYTE_W-1:0] cnt_ff;
   logic              sclk_rise;

   // Two-stage pin synchroniser plus one history stage for edges
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff <= 3'h4;
         s2_ff <= 3'h4;
         s3_ff <= 3'h4;
      end else if (ce) begin
         s1_ff <= {select_n, sdi_pin, sclk_pin};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Edge decoding on the synchronised copies
   assign sel_active = ~s2_ff[PIN_SEL];
   assign sel_start  = s3_ff[PIN_SEL] & ~s2_ff[PIN_SEL];
   assign sel_end    = ~s3_ff[PIN_SEL] & s2_ff[PIN_SEL];
   assign sclk_rise  = sel_active & ~s3_ff[PIN_SCLK] & s2_ff[PIN_SCLK];
   assign sclk_fall  = sel_active & s3_ff[PIN_SCLK] & ~s2_ff[PIN_SCLK];
   assign byte_done  = sclk_rise & (bit_ff == LAST_BIT);
   assign rx_byte    = {sr_ff[BYTE_W-2:0], s2_ff[PIN_SDI]};
   assign byte_cnt   = cnt_ff;

   // Input shifter, data taken on the rising clock edge
   always_ff @(posedge clk) begin
      if (rst || sel_start) begin
         bit_ff <= 3'h0;
         sr_ff  <= IDLE_BYTE;
         cnt_ff <= BYTE_CMD;
      end else if (ce && sclk_rise) begin
         bit_ff <= bit_ff + 3'h1;
         sr_ff  <= rx_byte;
         if (byte_done && cnt_ff != 8'hFF)
            cnt_ff <= cnt_ff + 8'h01;   // Saturates on long bursts
      end
   end

endmodule : rss_spi_port

`default_nettype wire

// ==== bench/rss_state_seq_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module rss_state_seq_asserts
   import rss_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       shutdown_pin,
   input wire logic       select_n,
   input wire logic       spi_sdo_oe_n,
   input wire logic       interrupt_request_n,
   input wire logic       clear_to_send,
   input wire logic [2:0] op_state,
   input wire logic       lp_clk_en,
   input wire logic       regulator_en,
   input wire logic       xtal_en,
   input wire logic       pll_en,
   input wire logic       pll_cal_en,
   input wire logic       pa_en,
   input wire logic       tx_active
);
   // One domain; reset quiets every check
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence tx_entry_s; $rose(tx_active); endsequence
   sequence irq_late_s; ##[300:340] !interrupt_request_n; endsequence
   shut_state_a: assert property (shutdown_pin [*4] |-> op_state == 3'h0)
      else $error("shutdown pin did not stop the device");
   shut_quiet_a: assert property (op_state < 3'h2 |-> spi_sdo_oe_n)
      else $error("serial output driven while powered down");
   seq_cts_a: assert property ((pll_cal_en || pa_en) && !tx_active |-> !clear_to_send)
      else $error("clear to send high while sequencing");
   tx_entry_a: assert property (tx_entry_s |-> clear_to_send && op_state == 3'h6)
      else $error("transmit entry without clear to send");
   irq_delay_a: assert property (tx_entry_s |-> irq_late_s)
      else $error("interrupt late after transmit entry");
   step_order_a: assert property ($rose(pa_en) |-> regulator_en && xtal_en && pll_en)
      else $error("power amplifier before earlier steps");
   cal_pll_a: assert property ($rose(pll_en) |-> ##[1:120] pll_cal_en)
      else $error("no calibration after synthesizer enable");
   ready_xtal_a: assert property (op_state == 3'h5 |-> xtal_en)
      else $error("crystal off in ready state");
   sleep_clk_a: assert property (op_state == 3'h3 |-> lp_clk_en)
      else $error("slow clock off in sleep");
   wake_a: assert property (op_state == 3'h3 && $fell(select_n) |-> ##[1:8] op_state == 3'h4)
      else $error("serial event did not wake the device");
endmodule : rss_state_seq_asserts
bind rss_state_seq rss_state_seq_asserts u_chk (.*);
`default_nettype wire

// ==== bench/rss_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rss_host_model (
   output logic     spi_sclk,
   output logic     spi_sdi,
   output logic     select_n,
   input wire logic spi_sdo
);
   // Idle bus: clock low, deselected
   initial begin
      spi_sclk = 1'b0;
      spi_sdi = 1'b0;
      select_n = 1'b1;
   end
   task automatic xfer(input logic [47:0] tx, input int nb,
                       output logic [47:0] rx);
      rx = 48'h0;
      select_n = 1'b0;
      for (int i = 0; i < nb * 8; i++) begin
         #80 spi_sdi = tx[47 - i];
         #80 spi_sclk = 1'b1;
         rx[47 - i] = spi_sdo;
         #160 spi_sclk = 1'b0;
      end
      #80 select_n = 1'b1;
      spi_sdi = ~spi_sdi; // Released line shows no stale bit
      #400;
   endtask : xfer
endmodule : rss_host_model
`default_nettype wire

// ==== bench/radio_state_sequencer_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module radio_state_sequencer_test;
   import rss_pkg::*;
   logic clk, rst, ce, shutdown_pin, spi_sclk, spi_sdi, select_n, spi_sdo;
   logic spi_sdo_oe_n, int_clear, tx_done, rx_done, interrupt_request_n;
   logic clear_to_send, initialised, boot_osc_en, lp_clk_en, regulator_en;
   logic xtal_en, pll_en, pll_cal_en, pa_en, tx_active, rx_active;
   logic [2:0] op_state, fast_reg_function_select_a, fast_reg_function_select_b;
   logic [2:0] fast_reg_function_select_c, fast_reg_function_select_d;
   logic [7:0]  int_status, is0;
   logic [47:0] rd;
   logic [2:0]  md [4];
   logic [7:0]  codes [4];
   int          mismatches, comparisons, seed;
   wire logic   sdo_line = spi_sdo_oe_n ? 1'b1 : spi_sdo; // Pulled up when idle
   rss_state_seq DUT (.*);
   rss_host_model host (.spi_sclk, .spi_sdi, .select_n, .spi_sdo(sdo_line));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wait_for(input logic [2:0] st);
      for (int n = 0; n < 20000 && op_state !== st; n++) @(negedge clk);
   endtask : wait_for
   function automatic logic [7:0] frr_exp(input logic [2:0] m, input logic [7:0] is);
      case (m)
         FRR_STATE: return {5'h00, op_spi_active};
         FRR_INT:   return is;
         FRR_CHIP:  return 8'h06;
         default:   return 8'h00;
      endcase
   endfunction : frr_exp
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   // Watchdog against a hung sequence
   initial begin
      #3000000;
      mismatches++;
      print_verdict();
   end
   // Main sequence
   initial begin
      seed = 88;
      {ce, rst, shutdown_pin, int_clear, tx_done, rx_done} = 6'h38;
      int_status = 8'h00;
      codes = '{CMD_FAST_A, CMD_FAST_B, CMD_FAST_C, CMD_FAST_D};
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (260) @(negedge clk);
      shutdown_pin = 1'b0;
      wait_for(op_standby);
      chk("state", {5'h00, op_standby}, {5'h00, op_state});
      chk("init", 8'h00, {7'h00, initialised});
      host.xfer({CMD_POWER_UP, 40'h0}, 1, rd);
      chk("init", 8'h01, {7'h00, initialised});
      chk("state", {5'h00, op_spi_active}, {5'h00, op_state});
      chk("boot osc", 8'h01, {7'h00, boot_osc_en});
      for (int k = 0; k < 4; k++) begin
         is0 = 8'($random(seed));
         int_status = is0;
         foreach (md[j])
            md[j] = 3'(k == 1 ? 0 : k == 0 ? j + 1 : $unsigned($random(seed)) % 5);
         {fast_reg_function_select_a, fast_reg_function_select_b} = {md[0], md[1]};
         {fast_reg_function_select_c, fast_reg_function_select_d} = {md[2], md[3]};
         fork
            host.xfer({codes[k], 40'h0}, 6, rd);
            begin repeat (60) @(negedge clk); int_status = ~is0; end
         join
         for (int j = 1; j < 6; j++)
            chk("fast", frr_exp(md[(k + j - 1) % 4], is0), rd[47 - 8 * j -: 8]);
      end
      int_status = 8'h00;
      host.xfer({CMD_START_TX, 8'h03, 32'h0}, 2, rd);
      chk("cts", 8'h00, {7'h00, clear_to_send});
      wait_for(op_tx);
      chk("cts", 8'h01, {7'h00, clear_to_send});
      fast_reg_function_select_a = FRR_STATE;
      repeat (130) @(negedge clk);
      host.xfer({CMD_FAST_A, 40'h0}, 2, rd);
      chk("fast", {5'h00, op_tx}, rd[39:32]);
      repeat (130) @(negedge clk);
      chk("irq", 8'h00, {7'h00, interrupt_request_n});
      int_clear = 1'b1;
      @(negedge clk) int_clear = 1'b0;
      tx_done = 1'b1;
      @(negedge clk) tx_done = 1'b0;
      wait_for(op_sleep);
      chk("state", {5'h00, op_sleep}, {5'h00, op_state});
      chk("irq", 8'h01, {7'h00, interrupt_request_n});
      chk("boot osc", 8'h00, {7'h00, boot_osc_en});
      host.xfer({CMD_CHANGE_ST, 8'h05, 32'h0}, 2, rd);
      wait_for(op_ready);
      chk("state", {5'h00, op_ready}, {5'h00, op_state});
      host.xfer({CMD_READ_CTS, 40'h0}, 2, rd);
      chk("cts byte", CTS_READY, rd[39:32]);
      chk("state", {5'h00, op_ready}, {5'h00, op_state});
      host.xfer({CMD_START_RX, 8'h05, 32'h0}, 2, rd);
      wait_for(op_rx);
      chk("rx", 8'h01, {7'h00, rx_active});
      rx_done = 1'b1;
      @(negedge clk) rx_done = 1'b0;
      wait_for(op_ready);
      chk("state", {5'h00, op_ready}, {5'h00, op_state});
      shutdown_pin = 1'b1;
      repeat (6) @(negedge clk);
      chk("state", 8'h00, {5'h00, op_state});
      chk("init", 8'h00, {7'h00, initialised});
      print_verdict();
   end
endmodule : radio_state_sequencer_test
`default_nettype wire
